// file: dcfifo_port_flags.sv
// dual-clock port fifo: port a writes, port b reads, two mailboxes, flags
// assumes port clocks and pins are slow against sys_clk (at least 3 sys_clk per phase)
`timescale 1ns/100ps
`default_nettype none

module dcfifo_port_flags
	import dcfifo_pkg::*;
(
	input  wire  logic              sys_clk,               // 20 mhz system clock
	input  wire  logic              rst,                   // async reset, active high
	input  wire  logic              ce,                    // clock enable, freezes all state
	input  wire  logic              psel,                  // apb select
	input  wire  logic              penable,               // apb enable
	input  wire  logic              pwrite,                // apb direction
	input  wire  logic [7:0]        paddr,                 // apb byte address
	input  wire  logic [31:0]       pwdata,                // apb write data
	output logic       [31:0]       prdata,                // apb read data
	output logic                    pready,                // apb ready
	output logic                    pslverr,               // apb error, unmapped address
	input  wire  logic              port_a_clock,          // port a clock pin
	input  wire  logic              port_a_select_n,       // port a select, low active
	input  wire  logic              port_a_write_not_read, // port a direction
	input  wire  logic              port_a_enable,         // port a enable
	input  wire  logic              port_a_mailbox_select, // port a mailbox select
	input  wire  logic [DATA_W-1:0] port_a_data_in,        // port a data pins in
	output logic       [DATA_W-1:0] port_a_data_out,       // port a data pins out
	output logic                    port_a_data_oe,        // port a output enable
	input  wire  logic              port_b_clock,          // port b clock pin
	input  wire  logic              port_b_select_n,       // port b select, low active
	input  wire  logic              port_b_read_not_write, // port b direction
	input  wire  logic              port_b_enable,         // port b enable
	input  wire  logic              port_b_mailbox_select, // port b mailbox select
	input  wire  logic [DATA_W-1:0] port_b_data_in,        // port b data pins in
	output logic       [DATA_W-1:0] port_b_data_out,       // port b data pins out
	output logic                    port_b_data_oe,        // port b output enable
	input  wire  logic              fall_through_mode,     // timing mode pin
	output logic                    empty_outready_flag,   // empty or output-ready
	output logic                    almost_empty_flag,     // almost-empty, low active
	output logic                    full_inready_flag,     // full or input-ready
	output logic                    almost_full_flag,      // almost-full, low active
	output logic                    a_to_b_mail_flag,      // low while a-to-b mail waits
	output logic                    b_to_a_mail_flag       // low while b-to-a mail waits
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [PTR_W-1:0] to_gray(input logic [PTR_W-1:0] b);
		to_gray = b ^ (b >> 1);
	endfunction

	function automatic logic [PTR_W-1:0] from_gray(input logic [PTR_W-1:0] g);
		from_gray = g;
		for (int i = PTR_W - 2; i >= 0; i--) begin
			from_gray[i] = g[i] ^ from_gray[i + 1];
		end
	endfunction

	function automatic logic port_fire(input logic edge_seen, input logic sel_n, input logic en,
		input logic dir, input logic mb);
		port_fire = edge_seen & ~sel_n & en & dir & mb;
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	port_a_pins_type a_raw, a_s1, a_s2;
	port_b_pins_type b_raw, b_s1, b_s2;
	logic            a_clk_prev_q;
	logic            b_clk_prev_q;
	logic            mode_s1_q, mode_s2_q;

	assign a_raw = '{clk: port_a_clock, sel_n: port_a_select_n, wnr: port_a_write_not_read,
		en: port_a_enable, mb: port_a_mailbox_select, data: port_a_data_in};
	assign b_raw = '{clk: port_b_clock, sel_n: port_b_select_n, rnw: port_b_read_not_write,
		en: port_b_enable, mb: port_b_mailbox_select, data: port_b_data_in};

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			a_s1         <= '{sel_n: 1'b1, default: '0};
			a_s2         <= '{sel_n: 1'b1, default: '0};
			b_s1         <= '{sel_n: 1'b1, default: '0};
			b_s2         <= '{sel_n: 1'b1, default: '0};
			a_clk_prev_q <= 1'b0;
			b_clk_prev_q <= 1'b0;
		end else if (ce) begin
			a_s1         <= a_raw;
			a_s2         <= a_s1;
			b_s1         <= b_raw;
			b_s2         <= b_s1;
			a_clk_prev_q <= a_s2.clk;
			b_clk_prev_q <= b_s2.clk;
		end
	end

	// mode synchroniser runs through reset so the pin level is settled at release
	always_ff @(posedge sys_clk) begin
		if (ce) begin
			mode_s1_q <= fall_through_mode;
			mode_s2_q <= mode_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// timing mode capture
	// ----------------------------------------------------------------
	logic mode_q, mode_taken_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mode_q       <= 1'b0;
			mode_taken_q <= 1'b0;
		end else if (ce && !mode_taken_q) begin
			mode_q       <= mode_s2_q;
			mode_taken_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// port decode
	// ----------------------------------------------------------------
	logic a_edge, b_edge;
	logic a_fifo_wr, a_mail_wr, a_mail_rd;
	logic b_fifo_rd, b_mail_wr, b_mail_rd;

	assign a_edge = a_s2.clk & ~a_clk_prev_q & mode_taken_q;
	assign b_edge = b_s2.clk & ~b_clk_prev_q & mode_taken_q;

	assign a_fifo_wr = port_fire(a_edge, a_s2.sel_n, a_s2.en, a_s2.wnr, ~a_s2.mb) & full_inready_flag;
	assign a_mail_wr = port_fire(a_edge, a_s2.sel_n, a_s2.en, a_s2.wnr, a_s2.mb) & a_to_b_mail_flag;
	assign a_mail_rd = port_fire(a_edge, a_s2.sel_n, a_s2.en, ~a_s2.wnr, a_s2.mb);
	assign b_fifo_rd = port_fire(b_edge, b_s2.sel_n, b_s2.en, b_s2.rnw, ~b_s2.mb);
	assign b_mail_wr = port_fire(b_edge, b_s2.sel_n, b_s2.en, ~b_s2.rnw, b_s2.mb) & b_to_a_mail_flag;
	assign b_mail_rd = port_fire(b_edge, b_s2.sel_n, b_s2.en, b_s2.rnw, b_s2.mb);

	// ----------------------------------------------------------------
	// write side, port a events
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] mem [0:(1 << ADDR_W) - 1];
	logic [PTR_W-1:0]  wr_bin_q, wr_gray_q, wr_next;
	logic [PTR_W-1:0]  rd_bin_q, rd_gray_q, rd_next;
	logic [PTR_W-1:0]  rd_gray_a1_q;
	logic [PTR_W-1:0]  fill_a;
	logic [11:0]       empty_offset_q, full_offset_q;

	assign wr_next = wr_bin_q + {{(PTR_W - 1){1'b0}}, a_fifo_wr};
	assign fill_a  = wr_next - from_gray(rd_gray_a1_q);

	always_ff @(posedge sys_clk) begin
		if (ce && a_fifo_wr) begin
			mem[wr_bin_q[ADDR_W-1:0]] <= a_s2.data;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wr_bin_q  <= '0;
			wr_gray_q <= '0;
		end else if (ce && a_fifo_wr) begin
			wr_bin_q  <= wr_next;
			wr_gray_q <= to_gray(wr_next);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_gray_a1_q      <= '0;
			full_inready_flag <= 1'b1;
			almost_full_flag  <= 1'b1;
		end else if (ce && a_edge) begin
			rd_gray_a1_q      <= rd_gray_q;
			full_inready_flag <= (fill_a != DEPTH);
			almost_full_flag  <= (fill_a < (DEPTH - full_offset_q));
		end
	end

	// ----------------------------------------------------------------
	// read side, port b events
	// ----------------------------------------------------------------
	logic [PTR_W-1:0]  wr_gray_b1_q, wr_gray_b2_q;
	logic [PTR_W-1:0]  fill_b;
	logic [DATA_W-1:0] out_word_q;
	logic              ft_avail, rd_load;

	assign ft_avail = (from_gray(wr_gray_b2_q) != rd_bin_q);
	assign rd_load  = mode_q ? (b_edge & ft_avail & (~empty_outready_flag | b_fifo_rd))
		: (b_fifo_rd & empty_outready_flag);
	assign rd_next  = rd_bin_q + {{(PTR_W - 1){1'b0}}, rd_load};
	assign fill_b   = from_gray(wr_gray_b1_q) - rd_next;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_bin_q   <= '0;
			rd_gray_q  <= '0;
			out_word_q <= '0;
		end else if (ce && rd_load) begin
			rd_bin_q   <= rd_next;
			rd_gray_q  <= to_gray(rd_next);
			out_word_q <= mem[rd_bin_q[ADDR_W-1:0]];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wr_gray_b1_q        <= '0;
			wr_gray_b2_q        <= '0;
			empty_outready_flag <= 1'b0;
			almost_empty_flag   <= 1'b0;
		end else if (ce && b_edge) begin
			wr_gray_b1_q      <= wr_gray_q;
			wr_gray_b2_q      <= wr_gray_b1_q;
			almost_empty_flag <= (fill_b > empty_offset_q);
			if (mode_q) begin
				empty_outready_flag <= rd_load | (empty_outready_flag & ~b_fifo_rd);
			end else begin
				empty_outready_flag <= (fill_b != '0);
			end
		end
	end

	// ----------------------------------------------------------------
	// mailboxes
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] a_to_b_mailbox_q, b_to_a_mailbox_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			a_to_b_mailbox_q <= '0;
			a_to_b_mail_flag <= 1'b1;
		end else if (ce) begin
			if (a_mail_wr) begin
				a_to_b_mailbox_q <= a_s2.data;
				a_to_b_mail_flag <= 1'b0;
			end else if (b_mail_rd) begin
				a_to_b_mail_flag <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			b_to_a_mailbox_q <= '0;
			b_to_a_mail_flag <= 1'b1;
		end else if (ce) begin
			if (b_mail_wr) begin
				b_to_a_mailbox_q <= b_s2.data;
				b_to_a_mail_flag <= 1'b0;
			end else if (a_mail_rd) begin
				b_to_a_mail_flag <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// data pin drivers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			port_a_data_oe  <= 1'b0;
			port_a_data_out <= '0;
			port_b_data_oe  <= 1'b0;
			port_b_data_out <= '0;
		end else if (ce) begin
			port_a_data_oe  <= ~a_s2.sel_n & ~a_s2.wnr;
			port_a_data_out <= b_to_a_mailbox_q;
			port_b_data_oe  <= ~b_s2.sel_n & b_s2.rnw;
			port_b_data_out <= b_s2.mb ? a_to_b_mailbox_q : out_word_q;
		end
	end

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	logic apb_setup, apb_done, apb_mapped;

	assign apb_setup  = psel & penable & ~pready;
	assign apb_done   = psel & penable & pready;
	assign apb_mapped = (paddr == OFS_EMPTY_OFFSET) | (paddr == OFS_FULL_OFFSET) | (paddr == OFS_STATUS);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else if (ce) begin
			pready  <= apb_setup;
			pslverr <= apb_setup & ~apb_mapped;
			if (apb_setup && !pwrite) begin
				unique case (paddr)
					OFS_EMPTY_OFFSET: prdata <= {20'h00000, empty_offset_q};
					OFS_FULL_OFFSET:  prdata <= {20'h00000, full_offset_q};
					OFS_STATUS: begin
						prdata                 <= '0;
						prdata[ST_EMPTY]       <= empty_outready_flag;
						prdata[ST_AEMPTY]      <= almost_empty_flag;
						prdata[ST_FULL]        <= full_inready_flag;
						prdata[ST_AFULL]       <= almost_full_flag;
						prdata[ST_MAIL_A]      <= a_to_b_mail_flag;
						prdata[ST_MAIL_B]      <= b_to_a_mail_flag;
						prdata[ST_MODE]        <= mode_q;
						prdata[ST_FILL +: 12]  <= wr_bin_q - rd_bin_q;
					end
					default:          prdata <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			empty_offset_q <= EMPTY_OFFSET_RST;
			full_offset_q  <= FULL_OFFSET_RST;
		end else if (ce && apb_done && pwrite) begin
			if (paddr == OFS_EMPTY_OFFSET) begin
				empty_offset_q <= {1'b0, pwdata[OFFSET_W-1:0]};
			end
			if (paddr == OFS_FULL_OFFSET) begin
				full_offset_q <= {1'b0, pwdata[OFFSET_W-1:0]};
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
		ce |=> (port_a_data_oe == $past(~a_s2.sel_n & ~a_s2.wnr)))
		else $error("port a drive enable wrong");
	b_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
		ce |=> (port_b_data_oe == $past(~b_s2.sel_n & b_s2.rnw)))
		else $error("port b drive enable wrong");
	full_block_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && !full_inready_flag) |=> (wr_bin_q == $past(wr_bin_q)))
		else $error("write taken while full");
	wr_step_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && a_fifo_wr) |=> (wr_bin_q == $past(wr_bin_q) + 12'h001))
		else $error("write pointer did not step");
	rd_step_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && !rd_load) |=> (rd_bin_q == $past(rd_bin_q)))
		else $error("read pointer moved without load");
	std_ignore_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && !mode_q && !empty_outready_flag) |=> $stable(out_word_q))
		else $error("output word changed while empty");
	mail_b_rd_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && b_mail_rd && !a_mail_wr) |=> a_to_b_mail_flag)
		else $error("a-to-b flag not raised by read");
	mail_a_rd_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && a_mail_rd && !b_mail_wr) |=> b_to_a_mail_flag)
		else $error("b-to-a flag not raised by read");
	ft_show_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && mode_q && b_edge && !empty_outready_flag && ft_avail) |=> empty_outready_flag)
		else $error("fall-through word not presented");
	ae_level_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && b_edge) |=> (almost_empty_flag == ($past(fill_b) > $past(empty_offset_q))))
		else $error("almost-empty level wrong");
endmodule
`default_nettype wire

// file: dcfifo_pkg.sv
// constants and pin bundles for the dual-clock port fifo with mailboxes
// assumes a single system clock far faster than either port clock
package dcfifo_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int          DATA_W = 36;
	localparam int          ADDR_W = 11;
	localparam int          PTR_W  = 12;
	localparam logic [11:0] DEPTH  = 12'h800;

	// ----------------------------------------------------------------
	// apb register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  OFS_EMPTY_OFFSET = 8'h00;
	localparam logic [7:0]  OFS_FULL_OFFSET  = 8'h04;
	localparam logic [7:0]  OFS_STATUS       = 8'h08;
	localparam logic [11:0] EMPTY_OFFSET_RST = 12'h010;
	localparam logic [11:0] FULL_OFFSET_RST  = 12'h010;
	localparam int          OFFSET_W         = 11;

	// status field positions
	localparam int ST_EMPTY  = 0;
	localparam int ST_AEMPTY = 1;
	localparam int ST_FULL   = 2;
	localparam int ST_AFULL  = 3;
	localparam int ST_MAIL_A = 4;
	localparam int ST_MAIL_B = 5;
	localparam int ST_MODE   = 6;
	localparam int ST_FILL   = 8;

	// ----------------------------------------------------------------
	// pin bundles
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              clk;
		logic              sel_n;
		logic              wnr;
		logic              en;
		logic              mb;
		logic [DATA_W-1:0] data;
	} port_a_pins_type;

	typedef struct packed {
		logic              clk;
		logic              sel_n;
		logic              rnw;
		logic              en;
		logic              mb;
		logic [DATA_W-1:0] data;
	} port_b_pins_type;

endpackage

// file: dcfifo_port_master.sv
// far-side bus master for one fifo port: free-running port clock and pins
// assumes the device samples these pins on sys_clk, several cycles per phase
`timescale 1ns/100ps
`default_nettype none
module dcfifo_port_master
	import dcfifo_pkg::*;
#(
	parameter int HALF = 4
) (
	input  wire logic              sys_clk, // system clock
	output logic                   pclk,    // port clock pin
	output logic                   sel_n,   // select, low active
	output logic                   dir,     // direction pin
	output logic                   en,      // enable
	output logic                   mb,      // mailbox select
	output logic [DATA_W-1:0]      data     // data toward the device
);
	int   cnt = 0;
	event took;

	initial begin
		pclk = 1'b0;
		sel_n = 1'b1;
		dir = 1'b0;
		en = 1'b0;
		mb = 1'b0;
		data = '0;
	end

	always @(posedge sys_clk) begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1) begin
			pclk <= ~pclk;
		end
	end

	task automatic xfer(input logic s, input logic d, input logic e, input logic m, input logic [DATA_W-1:0] v);
		@(negedge pclk);
		@(posedge sys_clk);
		sel_n <= s;
		dir <= d;
		en <= e;
		mb <= m;
		data <= v;
		@(posedge pclk);
		-> took;
		repeat (HALF + 2) @(posedge sys_clk);
		en <= 1'b0;
		// released data lines show the inverse
		data <= ~v;
	endtask
endmodule
`default_nettype wire

// file: test_dcfifo_port_flags.sv
// self-checking bench for the dual-clock port fifo
// assumes package, design and port master are compiled first
`timescale 1ns/100ps
`default_nettype none
module test_dcfifo_port_flags;
	import dcfifo_pkg::*;
	logic              sys_clk = 1'b0;
	logic              rst = 1'b1;
	logic              fall_through_mode = 1'b0;
	logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]        paddr = 8'h00;
	logic [31:0]       pwdata = 32'h0, prdata, rd;
	logic              pready, pslverr, err;
	logic [DATA_W-1:0] port_a_data_in, port_a_data_out, a_drv, port_b_data_in, port_b_data_out, b_drv;
	logic              port_a_clock, port_a_select_n, port_a_write_not_read, port_a_enable, port_a_mailbox_select;
	logic              port_b_clock, port_b_select_n, port_b_read_not_write, port_b_enable, port_b_mailbox_select;
	logic              port_a_data_oe, port_b_data_oe, a_to_b_mail_flag, b_to_a_mail_flag;
	logic              empty_outready_flag, almost_empty_flag, full_inready_flag, almost_full_flag;
	logic [DATA_W-1:0] w [4] = '{36'h1_2345_6789, 36'h9_8765_4321, 36'ha_5a5a_5a5a, 36'h5_a5a5_a5a5};
	int                n_fail = 0;
	int                checked = 0;
	int                n;

	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	assign port_a_data_in = port_a_data_oe ? port_a_data_out : a_drv;
	assign port_b_data_in = port_b_data_oe ? port_b_data_out : b_drv;

	dcfifo_port_flags u_dut (.sys_clk, .rst, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .port_a_clock, .port_a_select_n, .port_a_write_not_read, .port_a_enable,
		.port_a_mailbox_select, .port_a_data_in, .port_a_data_out, .port_a_data_oe, .port_b_clock,
		.port_b_select_n, .port_b_read_not_write, .port_b_enable, .port_b_mailbox_select, .port_b_data_in,
		.port_b_data_out, .port_b_data_oe, .fall_through_mode, .empty_outready_flag, .almost_empty_flag,
		.full_inready_flag, .almost_full_flag, .a_to_b_mail_flag, .b_to_a_mail_flag);
	dcfifo_port_master #(.HALF(4)) u_pa (.sys_clk, .pclk(port_a_clock), .sel_n(port_a_select_n),
		.dir(port_a_write_not_read), .en(port_a_enable), .mb(port_a_mailbox_select), .data(a_drv));
	dcfifo_port_master #(.HALF(5)) u_pb (.sys_clk, .pclk(port_b_clock), .sel_n(port_b_select_n),
		.dir(port_b_read_not_write), .en(port_b_enable), .mb(port_b_mailbox_select), .data(b_drv));

	task automatic check(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic check_rng(input string what, input int lo, input int hi, input int got);
		checked++;
		if (got < lo || got > hi) begin
			n_fail++;
			$display("unexpected %s: expected %0d to %0d, seen %0d", what, lo, hi, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr_a(input logic [DATA_W-1:0] v);
		u_pa.xfer(1'b0, 1'b1, 1'b1, 1'b0, v);
	endtask

	task automatic rd_b;
		u_pb.xfer(1'b0, 1'b1, 1'b1, 1'b0, '0);
	endtask

	task automatic edges(input logic on_b, input int k);
		repeat (k) begin
			if (on_b) @(posedge port_b_clock);
			else @(posedge port_a_clock);
		end
		repeat (6) @(posedge sys_clk);
	endtask

	// edges of the flag's own port from the other port's transfer until the flag rises
	task automatic count_sync(input logic on_b, output int cnt);
		cnt = 0;
		if (on_b) @(u_pa.took);
		else @(u_pb.took);
		while ((on_b ? empty_outready_flag : full_inready_flag) !== 1'b1 && cnt < 8) begin
			edges(on_b, 1);
			cnt++;
		end
	endtask

	task automatic do_reset(input logic m);
		@(posedge sys_clk);
		rst <= 1'b1;
		fall_through_mode <= m;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		check("empty flag", 1'b0, empty_outready_flag);
		check("almost empty", 1'b0, almost_empty_flag);
		check("full flag", 1'b1, full_inready_flag);
		check("almost full", 1'b1, almost_full_flag);
	endtask

	task automatic t_regs;
		apb(1'b0, OFS_EMPTY_OFFSET, 32'h0);
		check("empty offset", 36'(EMPTY_OFFSET_RST), 36'(rd));
		apb(1'b0, 8'h0c, 32'h0);
		check("unmapped error", 1'b1, err);
		apb(1'b1, OFS_EMPTY_OFFSET, 32'h2);
		apb(1'b0, OFS_EMPTY_OFFSET, 32'h0);
		check("empty offset", 36'h2, 36'(rd));
	endtask

	task automatic t_mail;
		u_pa.xfer(1'b0, 1'b1, 1'b1, 1'b1, w[1]);
		check("a to b flag", 1'b0, a_to_b_mail_flag);
		u_pb.xfer(1'b0, 1'b1, 1'b1, 1'b1, '0);
		check("b mail data", w[1], port_b_data_out);
		check("a to b flag", 1'b1, a_to_b_mail_flag);
		u_pb.xfer(1'b0, 1'b0, 1'b1, 1'b1, w[2]);
		check("b drive", 1'b0, port_b_data_oe);
		check("b to a flag", 1'b0, b_to_a_mail_flag);
		u_pa.xfer(1'b0, 1'b0, 1'b1, 1'b1, '0);
		check("a mail data", w[2], port_a_data_out);
		check("a drive", 1'b1, port_a_data_oe);
		check("b to a flag", 1'b1, b_to_a_mail_flag);
		u_pa.xfer(1'b0, 1'b1, 1'b0, 1'b0, '0);
		check("a drive", 1'b0, port_a_data_oe);
	endtask

	task automatic t_std;
		fork
			wr_a(w[0]);
			count_sync(1'b1, n);
		join
		check_rng("empty flag edges", 2, 3, n);
		rd_b;
		check("b data", w[0], port_b_data_out);
		check("b drive", 1'b1, port_b_data_oe);
		check("empty flag", 1'b0, empty_outready_flag);
		rd_b;
		check("b data kept", w[0], port_b_data_out);
		wr_a(w[1]);
		wr_a(w[2]);
		edges(1'b1, 3);
		check("almost empty", 1'b0, almost_empty_flag);
		wr_a(w[3]);
		edges(1'b1, 3);
		check("almost empty", 1'b1, almost_empty_flag);
		for (int i = 1; i < 4; i++) begin
			rd_b;
			check("b data", w[i], port_b_data_out);
			check("almost empty", 1'b0, almost_empty_flag);
		end
	endtask

	task automatic t_full;
		for (int i = 0; i < 2048; i++) begin
			wr_a(DATA_W'(i));
			if (i == 2030 || i == 2031) begin
				edges(1'b0, 3);
				check("almost full", (i == 2030), almost_full_flag);
			end
		end
		edges(1'b0, 3);
		check("full flag", 1'b0, full_inready_flag);
		wr_a(w[3]);
		apb(1'b0, OFS_STATUS, 32'h0);
		check("fill count", 36'h800, 36'(rd[19:8]));
		fork
			rd_b;
			count_sync(1'b0, n);
		join
		check_rng("full flag edges", 2, 3, n);
		check("b data", 36'h0, port_b_data_out);
		apb(1'b0, OFS_STATUS, 32'h0);
		check("fill count", 36'h7ff, 36'(rd[19:8]));
	endtask

	task automatic t_ft;
		fork
			wr_a(w[0]);
			count_sync(1'b1, n);
		join
		check_rng("ready edges", 3, 4, n);
		check("b data", w[0], port_b_data_out);
		wr_a(w[1]);
		edges(1'b1, 3);
		check("b data held", w[0], port_b_data_out);
		rd_b;
		check("b data", w[1], port_b_data_out);
		rd_b;
		check("output ready", 1'b0, empty_outready_flag);
		check("b data held", w[1], port_b_data_out);
	endtask

	task automatic print_verdict;
		$display("comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		do_reset(1'b0);
		t_regs;
		t_mail;
		t_std;
		t_full;
		do_reset(1'b1);
		t_ft;
		print_verdict;
	end

	initial begin
		repeat (90000) @(posedge sys_clk);
		n_fail++;
		print_verdict;
	end
endmodule
`default_nettype wire
